// File: include/cptx_regs.vh
// Register numbers, field positions and fixed values of the control
// coprocessor block. Included by the design file and the testbench, definitions only.
`ifndef CPTX_REGS_VH
`define CPTX_REGS_VH
// Coprocessor register numbers
`define CPTX_IDX_INDEX      5'h00
`define CPTX_IDX_RANDOM     5'h01
`define CPTX_IDX_LO0        5'h02
`define CPTX_IDX_LO1        5'h03
`define CPTX_IDX_CONTEXT    5'h04
`define CPTX_IDX_PAGEMASK   5'h05
`define CPTX_IDX_WIRED      5'h06
`define CPTX_IDX_BADVA      5'h08
`define CPTX_IDX_COUNT      5'h09
`define CPTX_IDX_HI         5'h0a
`define CPTX_IDX_COMPARE    5'h0b
`define CPTX_IDX_STATUS     5'h0c
`define CPTX_IDX_CAUSE      5'h0d
`define CPTX_IDX_RESTART    5'h0e
`define CPTX_IDX_CONFIG     5'h10
`define CPTX_IDX_LINKED_LOAD_PHYSICAL_ADDRESS     5'h11
`define CPTX_IDX_EXTENDED_PAGE_TABLE_CONTEXT   5'h14
`define CPTX_IDX_CHECK      5'h1a
`define CPTX_IDX_CFAULT     5'h1b
`define CPTX_IDX_CACHE_TAG_LOW      5'h1c
`define CPTX_IDX_CACHE_TAG_HIGH      5'h1d
`define CPTX_IDX_ERRRESTART 5'h1e
// Configuration fixed fields
`define CPTX_CFG_CACHE_SIZE 3'h2
`define CPTX_CFG_LINE_32B   1'h1
`define CPTX_CFG_ECR_MAX    3'h6
`define CPTX_CFG_EP_MAX     4'h8
// Status bit positions
`define CPTX_ST_IE          0
`define CPTX_ST_EXL         1
// Uncached coherency code
`define CPTX_COH_UNCACHED   3'h2
// Exception codes in the reason register
`define CPTX_EXC_MOD        5'h01
`define CPTX_EXC_TLBL       5'h02
`define CPTX_EXC_TLBS       5'h03
`endif

// File: design/cptx_core.v
// Control coprocessor: configuration, linked-address and cache-tag
// registers, TLB lookup and instructions, exception entry, context.
// Assumes the pipeline presents one coprocessor operation per cycle and
// holds its address and data valid while the strobe is high.
//
// How it works
// - Clock ratio field: divide by value plus two
// - Write pattern field selects doubleword spacing
// - Byte order bit: 0 little, 1 big
// - Cache line size bits read one
// - Linked load captures physical bits 35:4
// - Low tag loaded by cache op or move, high tag by move only
// - Index store tag computes even parity
// - Low tag keeps all 32 bits
// - Low tag: tag 35:12, state, parity, order
// - Compare identifier unless entry is global
// - Compare upper page bits under page mask
// - Return frame, coherency, dirty, valid bits
// - Miss, modify or invalid exceptions raised
// - Coherency 010 bypasses the cache
// - Probe, read, write indexed, write random
// - Exception: kernel mode, interrupts off, vector
// - Restart address, branch address in slot
// - Exception registers at fixed numbers
// - Miss writes bad page into context
// - Page table base kept on hardware update
// - Bad page holds address bits 31:13
// - Kernel segment coherency is software writable
// - Other configuration fields latched at reset
`timescale 1ns/10ps
`include "cptx_regs.vh"
module cptx_core
#(
  parameter ENTRIES  = 48,                       // TLB entry count
  parameter [63:0] HANDLER_VEC = 64'hffffffff80000180 // Exception target
)
(
  input  wire        sys_clk_i,        // Core clock
  input  wire        rst_b_i,          // Asynchronous reset, active low
  input  wire [2:0]  mode_clk_ratio_i, // Reset strap: clock ratio
  input  wire [3:0]  mode_wr_pattern_i,// Reset strap: write pattern
  input  wire        mode_big_end_i,   // Reset strap: byte order
  input  wire        mtc_i,            // Move to coprocessor strobe
  input  wire [4:0]  reg_num_i,        // Register number
  input  wire [63:0] wdata_i,          // Move data
  output reg  [63:0] rdata_o,          // Move-from data
  input  wire        tlb_probe_op_i,           // Probe
  input  wire        tlb_read_op_i,           // Read indexed
  input  wire        tlb_write_indexed_op_i,          // Write indexed
  input  wire        tlb_write_random_op_i,          // Write random
  input  wire        ll_i,             // Linked load done
  input  wire [35:0] ll_paddr_i,       // Its physical address
  input  wire        ist_i,            // Index store tag op
  input  wire        ilt_i,            // Index load tag op
  input  wire [31:0] cache_tag_i,      // Tag read by load-tag op
  output reg  [31:0] cache_tag_o,      // Tag with parity for store
  input  wire        xlat_i,           // Translate request
  input  wire        xlat_store_i,     // Request is a store
  input  wire [63:0] xlat_va_i,        // Virtual address
  output reg  [35:0] xlat_pa_o,        // Physical address
  output reg         xlat_uncached_o,  // Bypass cache
  output reg         xlat_hit_o,       // Valid translation
  input  wire        exc_i,            // Other exception detected
  input  wire [4:0]  exc_code_i,       // Its code
  input  wire [63:0] exc_pc_i,         // Faulting instruction address
  input  wire        exc_in_slot_i,    // Faulting in delay slot
  output reg         exc_taken_o,      // Exception entry pulse
  output reg  [63:0] fetch_vec_o,      // Redirect target
  output wire        kernel_mode_o,    // Running in kernel mode
  output wire        int_enable_o      // Interrupts enabled
);
  // Reset synchroniser
  reg rst_s1_reg, rst_s2_reg;
  always @(posedge sys_clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  wire rst_b = rst_s2_reg;

  // Highest entry number, cut to the index width
  localparam integer LAST_ENTRY = ENTRIES - 1;
  localparam [5:0]   LAST_IDX   = LAST_ENTRY[5:0];

  // TLB arrays
  reg [26:0] tlb_vpn2 [0:ENTRIES-1];   // VA bits 39:13
  reg [11:0] tlb_mask [0:ENTRIES-1];   // Page mask 24:13
  reg [7:0]  tlb_address_space_identifier [0:ENTRIES-1];   // Space identifier
  reg        tlb_g    [0:ENTRIES-1];   // Global
  reg [29:0] tlb_lo0  [0:ENTRIES-1];   // Even page frame/flags
  reg [29:0] tlb_lo1  [0:ENTRIES-1];   // Odd page frame/flags

  // Coprocessor registers
  reg [5:0]  index_reg;
  reg        probe_fail_reg;
  reg [5:0]  random_reg;
  reg [5:0]  wired_reg;
  reg [29:0] lo0_reg, lo1_reg;         // Frame 29:6, C 5:3, D, V, G
  reg [11:0] pmask_reg;
  reg [26:0] hi_vpn2_reg;
  reg [7:0]  hi_address_space_identifier_reg;
  reg [40:0] pte_base_reg;             // Context 63:23
  reg [18:0] bad_pair_reg;             // Context 22:4
  reg [63:0] badva_reg;
  reg [31:0] count_reg, compare_reg;
  reg [31:0] status_reg, cause_reg;
  reg [63:0] restart_reg, err_restart_reg;
  reg [31:0] check_reg;
  reg [31:0] linked_load_physical_address_reg;
  reg [31:0] tag_low_reg, tag_high_reg;
  reg [2:0]  k0_coh_reg;
  reg [2:0]  ecr_reg;
  reg [3:0]  ep_reg;
  reg        be_reg;
  reg        straps_done_reg;

  // Parity over the tag bits, parity bit excluded
  function even_par;
    input [31:0] t;
    begin
      even_par = ^{t[31:1]};
    end
  endfunction

  // Configuration word from fields
  wire [31:0] config_word =
    {1'b0, ecr_reg, ep_reg, 2'h0, 1'b0, 1'b0, 2'h0, 1'b1, 1'b0,
     be_reg, 1'b1, 1'b1, 1'b0,
     `CPTX_CFG_CACHE_SIZE, `CPTX_CFG_CACHE_SIZE,
     `CPTX_CFG_LINE_32B, `CPTX_CFG_LINE_32B, 1'b0,
     k0_coh_reg};

  // Associative match for translation and probe
  reg        m_hit;
  reg [5:0]  m_idx;
  reg [11:0] m_mask;
  integer    i;
  always @*
  begin
    m_hit  = 1'b0;
    m_idx  = 6'h00;
    m_mask = 12'h000;
    for (i = 0; i < ENTRIES; i = i + 1)
      if (((tlb_vpn2[i] ^ (xlat_i ? xlat_va_i[39:13] : hi_vpn2_reg))
           & ~{15'h0, tlb_mask[i]}) == 27'h0
          && (tlb_g[i] || tlb_address_space_identifier[i] == hi_address_space_identifier_reg)
          && !m_hit)
      begin
        m_hit  = 1'b1;
        m_idx  = i[5:0];
        m_mask = tlb_mask[i];
      end
  end

  // Even or odd half selected by the lowest unmasked page bit
  wire       odd = |(xlat_va_i[24:12] & {m_mask, 1'b1} &
                     ~{1'b0, m_mask});
  wire [29:0] ent = odd ? tlb_lo1[m_idx] : tlb_lo0[m_idx];
  wire ent_v = ent[1];
  wire ent_d = ent[2];
  wire miss  = xlat_i && !m_hit;
  wire inval = xlat_i && m_hit && !ent_v;
  wire modx  = xlat_i && m_hit && ent_v && xlat_store_i && !ent_d;
  wire tlb_exc = miss || inval || modx;
  wire any_exc = tlb_exc || exc_i;
  wire [35:0] pa_off_mask = {12'h000, m_mask, 12'hfff};
  wire [35:0] pa = ({ent[29:6], 12'h000} & ~pa_off_mask) |
                   ({12'h000, xlat_va_i[23:0]} & pa_off_mask);

  // Translation result outputs
  always @(posedge sys_clk_i or negedge rst_b)
    if (!rst_b)
    begin
      xlat_pa_o       <= 36'h0;
      xlat_uncached_o <= 1'b0;
      xlat_hit_o      <= 1'b0;
    end
    else
    begin
      xlat_pa_o       <= pa;
      xlat_uncached_o <= (ent[5:3] == `CPTX_COH_UNCACHED);
      xlat_hit_o      <= xlat_i && !tlb_exc;
    end

  // TLB writes from indexed or random operations
  wire [5:0] wr_idx = tlb_write_random_op_i ? random_reg : index_reg;
  always @(posedge sys_clk_i)
    if (tlb_write_indexed_op_i || tlb_write_random_op_i)
    begin
      tlb_vpn2[wr_idx] <= hi_vpn2_reg;
      tlb_mask[wr_idx] <= pmask_reg;
      tlb_address_space_identifier[wr_idx] <= hi_address_space_identifier_reg;
      tlb_g[wr_idx]    <= lo0_reg[0] & lo1_reg[0];
      tlb_lo0[wr_idx]  <= lo0_reg;
      tlb_lo1[wr_idx]  <= lo1_reg;
    end

  // Register updates
  wire wr_cfg = mtc_i && reg_num_i == `CPTX_IDX_CONFIG;
  always @(posedge sys_clk_i or negedge rst_b)
    if (!rst_b)
    begin
      index_reg <= 6'h0; probe_fail_reg <= 1'b0;
      random_reg <= LAST_IDX; wired_reg <= 6'h0;
      lo0_reg <= 30'h0; lo1_reg <= 30'h0; pmask_reg <= 12'h0;
      hi_vpn2_reg <= 27'h0; hi_address_space_identifier_reg <= 8'h0;
      pte_base_reg <= 41'h0; bad_pair_reg <= 19'h0;
      badva_reg <= 64'h0; count_reg <= 32'h0; compare_reg <= 32'h0;
      status_reg <= 32'h00400004; cause_reg <= 32'h0;
      restart_reg <= 64'h0; err_restart_reg <= 64'h0;
      check_reg <= 32'h0; linked_load_physical_address_reg <= 32'h0;
      tag_low_reg <= 32'h0; tag_high_reg <= 32'h0;
      k0_coh_reg <= 3'h0; ecr_reg <= 3'h0; ep_reg <= 4'h0;
      be_reg <= 1'b0; straps_done_reg <= 1'b0;
      exc_taken_o <= 1'b0; fetch_vec_o <= 64'h0;
      cache_tag_o <= 32'h0;
    end
    else
    begin
      count_reg   <= count_reg + 32'h1;
      exc_taken_o <= 1'b0;
      // Straps caught once after release
      if (!straps_done_reg)
      begin
        straps_done_reg <= 1'b1;
        ecr_reg <= (mode_clk_ratio_i > `CPTX_CFG_ECR_MAX) ?
                   `CPTX_CFG_ECR_MAX : mode_clk_ratio_i;
        ep_reg  <= (mode_wr_pattern_i > `CPTX_CFG_EP_MAX) ?
                   4'h0 : mode_wr_pattern_i;
        be_reg  <= mode_big_end_i;
      end
      // Random index walks down to the wired bound
      if (random_reg <= wired_reg)
        random_reg <= LAST_IDX;
      else
        random_reg <= random_reg - 6'h1;
      // Moves from the pipeline
      if (mtc_i)
        case (reg_num_i)
          `CPTX_IDX_INDEX:    index_reg <= wdata_i[5:0];
          `CPTX_IDX_LO0:      lo0_reg <= wdata_i[29:0];
          `CPTX_IDX_LO1:      lo1_reg <= wdata_i[29:0];
          `CPTX_IDX_CONTEXT:  pte_base_reg <= wdata_i[63:23];
          `CPTX_IDX_PAGEMASK: pmask_reg <= wdata_i[24:13];
          `CPTX_IDX_WIRED:
          begin
            wired_reg  <= wdata_i[5:0];
            random_reg <= LAST_IDX;
          end
          `CPTX_IDX_COUNT:    count_reg <= wdata_i[31:0];
          `CPTX_IDX_HI:
          begin
            hi_vpn2_reg <= wdata_i[39:13];
            hi_address_space_identifier_reg <= wdata_i[7:0];
          end
          `CPTX_IDX_COMPARE:
          begin
            compare_reg <= wdata_i[31:0];
            cause_reg[15] <= 1'b0;
          end
          `CPTX_IDX_STATUS:   status_reg <= wdata_i[31:0];
          `CPTX_IDX_CAUSE:    cause_reg[9:8] <= wdata_i[9:8];
          `CPTX_IDX_RESTART:  restart_reg <= wdata_i;
          `CPTX_IDX_LINKED_LOAD_PHYSICAL_ADDRESS:   linked_load_physical_address_reg <= wdata_i[31:0];
          `CPTX_IDX_CHECK:    check_reg <= wdata_i[31:0];
          `CPTX_IDX_CACHE_TAG_LOW:    tag_low_reg <= wdata_i[31:0];
          `CPTX_IDX_CACHE_TAG_HIGH:    tag_high_reg <= wdata_i[31:0];
          `CPTX_IDX_ERRRESTART: err_restart_reg <= wdata_i;
          default: ;
        endcase
      if (wr_cfg)
        k0_coh_reg <= wdata_i[2:0];
      // Timer match sets its pending bit, winning over the clear
      if (count_reg == compare_reg)
        cause_reg[15] <= 1'b1;
      // Linked load address
      if (ll_i)
        linked_load_physical_address_reg <= ll_paddr_i[35:4];
      // Cache tag operations
      if (ilt_i)
        tag_low_reg <= cache_tag_i;
      if (ist_i)
        cache_tag_o <= {tag_low_reg[31:1],
                        even_par(tag_low_reg)};
      // TLB probe and read
      if (tlb_probe_op_i)
      begin
        probe_fail_reg <= !m_hit;
        if (m_hit)
          index_reg <= m_idx;
      end
      if (tlb_read_op_i)
      begin
        hi_vpn2_reg <= tlb_vpn2[index_reg];
        hi_address_space_identifier_reg <= tlb_address_space_identifier[index_reg];
        pmask_reg   <= tlb_mask[index_reg];
        lo0_reg     <= tlb_lo0[index_reg];
        lo1_reg     <= tlb_lo1[index_reg];
      end
      // Exception entry
      if (any_exc)
      begin
        exc_taken_o <= 1'b1;
        fetch_vec_o <= HANDLER_VEC;
        status_reg[`CPTX_ST_EXL] <= 1'b1;
        status_reg[`CPTX_ST_IE]  <= 1'b0;
        restart_reg <= exc_in_slot_i ? exc_pc_i - 64'h4 : exc_pc_i;
        cause_reg[31] <= exc_in_slot_i;
        cause_reg[6:2] <= exc_i ? exc_code_i :
                          modx ? `CPTX_EXC_MOD :
                          xlat_store_i ? `CPTX_EXC_TLBS : `CPTX_EXC_TLBL;
      end
      if (tlb_exc)
      begin
        bad_pair_reg <= xlat_va_i[31:13];
        hi_vpn2_reg  <= xlat_va_i[39:13];
        if (!status_reg[`CPTX_ST_EXL])
          badva_reg <= xlat_va_i;
      end
    end

  assign kernel_mode_o = status_reg[`CPTX_ST_EXL] || status_reg[2] ||
                         status_reg[4:3] == 2'h0;
  assign int_enable_o  = status_reg[`CPTX_ST_IE] &&
                         !status_reg[`CPTX_ST_EXL] && !status_reg[2];

  // Move-from read mux, by register number
  always @*
  begin
    rdata_o = 64'h0;
    case (reg_num_i)
      `CPTX_IDX_INDEX:      rdata_o = {32'h0, probe_fail_reg, 25'h0, index_reg};
      `CPTX_IDX_RANDOM:     rdata_o = {58'h0, random_reg};
      `CPTX_IDX_LO0:        rdata_o = {34'h0, lo0_reg};
      `CPTX_IDX_LO1:        rdata_o = {34'h0, lo1_reg};
      `CPTX_IDX_CONTEXT:    rdata_o = {pte_base_reg, bad_pair_reg, 4'h0};
      `CPTX_IDX_PAGEMASK:   rdata_o = {39'h0, pmask_reg, 13'h0};
      `CPTX_IDX_WIRED:      rdata_o = {58'h0, wired_reg};
      `CPTX_IDX_BADVA:      rdata_o = badva_reg;
      `CPTX_IDX_COUNT:      rdata_o = {32'h0, count_reg};
      `CPTX_IDX_HI:         rdata_o = {24'h0, hi_vpn2_reg, 5'h0, hi_address_space_identifier_reg};
      `CPTX_IDX_COMPARE:    rdata_o = {32'h0, compare_reg};
      `CPTX_IDX_STATUS:     rdata_o = {32'h0, status_reg};
      `CPTX_IDX_CAUSE:      rdata_o = {32'h0, cause_reg};
      `CPTX_IDX_RESTART:    rdata_o = restart_reg;
      `CPTX_IDX_CONFIG:     rdata_o = {32'h0, config_word};
      `CPTX_IDX_LINKED_LOAD_PHYSICAL_ADDRESS:     rdata_o = {32'h0, linked_load_physical_address_reg};
      `CPTX_IDX_EXTENDED_PAGE_TABLE_CONTEXT:   rdata_o = {pte_base_reg[40:10], 2'h0,
                                       xlat_va_i[39:13], 4'h0};
      `CPTX_IDX_CHECK:      rdata_o = {32'h0, check_reg};
      `CPTX_IDX_CACHE_TAG_LOW:      rdata_o = {32'h0, tag_low_reg};
      `CPTX_IDX_CACHE_TAG_HIGH:      rdata_o = {32'h0, tag_high_reg};
      `CPTX_IDX_ERRRESTART: rdata_o = err_restart_reg;
      default:              rdata_o = 64'h0;
    endcase
  end
endmodule

// File: testbench/cptx_core_chk.sv
// Checker for the control coprocessor: exception entry, lookup result,
// tag parity, configuration constants. Sees only the core's ports.
`timescale 1ns/10ps
module cptx_core_chk
#(
  parameter [63:0] HANDLER_VEC = 64'hffffffff80000180 // Exception target
)
(
  input wire        sys_clk_i,     // Core clock
  input wire        rst_b_i,       // Reset, active low
  input wire        mtc_i,         // Move strobe
  input wire [4:0]  reg_num_i,     // Register number
  input wire [63:0] rdata_o,       // Read data
  input wire        ll_i,          // Linked load
  input wire [35:0] ll_paddr_i,    // Linked address
  input wire        ist_i,         // Store tag op
  input wire [31:0] cache_tag_o,   // Tag with parity
  input wire        xlat_i,        // Translate request
  input wire [63:0] xlat_va_i,     // Virtual address
  input wire        xlat_hit_o,    // Valid translation
  input wire        exc_i,         // Other exception
  input wire [63:0] exc_pc_i,      // Faulting address
  input wire        exc_in_slot_i, // Delay slot flag
  input wire        exc_taken_o,   // Entry pulse
  input wire [63:0] fetch_vec_o,   // Redirect target
  input wire        kernel_mode_o, // Kernel mode
  input wire        int_enable_o   // Interrupts on
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  wire [31:0] ll_pa_hi = ll_paddr_i[35:4]; // Captured linked bits
  wire [18:0] va_page  = xlat_va_i[31:13]; // Page pair number
  property p_exc_entry; exc_i |=> exc_taken_o; endproperty
  a_exc_entry: assert property (p_exc_entry)
    else $error("exception not taken");
  property p_vec; exc_taken_o |-> fetch_vec_o == HANDLER_VEC; endproperty
  a_vec: assert property (p_vec)
    else $error("wrong redirect target");
  property p_int_off; exc_taken_o |-> !int_enable_o && kernel_mode_o;
  endproperty
  a_int_off: assert property (p_int_off)
    else $error("mode or interrupts wrong on entry");
  property p_miss; xlat_i && !exc_i ##1 !xlat_hit_o |-> exc_taken_o;
  endproperty
  a_miss: assert property (p_miss)
    else $error("failed lookup without exception");
  property p_par; ist_i |=> !(^cache_tag_o); endproperty
  a_par: assert property (p_par)
    else $error("tag parity not even");
  property p_cfg_fixed; reg_num_i == 5'h10 |->
    {rdata_o[31], rdata_o[23:16], rdata_o[14:3]} == {1'b0, 8'h02, 12'hc96};
  endproperty
  a_cfg_fixed: assert property (p_cfg_fixed)
    else $error("configuration constant wrong");
  property p_cfg_ratio; reg_num_i == 5'h10 |-> rdata_o[30:28] <= 3'h6;
  endproperty
  a_cfg_ratio: assert property (p_cfg_ratio)
    else $error("reserved clock ratio");
  property p_ll; ll_i && !mtc_i ##1 reg_num_i == 5'h11 |->
    rdata_o[31:0] == $past(ll_pa_hi); endproperty
  a_ll: assert property (p_ll)
    else $error("linked address not captured");
  property p_restart; exc_i && int_enable_o && !xlat_i ##1
    reg_num_i == 5'h0e |-> rdata_o == ($past(exc_in_slot_i) ?
    $past(exc_pc_i) - 64'h4 : $past(exc_pc_i)); endproperty
  a_restart: assert property (p_restart)
    else $error("restart address wrong");
  property p_ctx; xlat_i && int_enable_o ##1 !xlat_hit_o &&
    reg_num_i == 5'h04 |-> rdata_o[22:4] == $past(va_page); endproperty
  a_ctx: assert property (p_ctx)
    else $error("bad page field wrong");
endmodule
bind cptx_core cptx_core_chk #(.HANDLER_VEC(HANDLER_VEC)) u_chk (
  .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .mtc_i(mtc_i),
  .reg_num_i(reg_num_i), .rdata_o(rdata_o), .ll_i(ll_i),
  .ll_paddr_i(ll_paddr_i), .ist_i(ist_i), .cache_tag_o(cache_tag_o),
  .xlat_i(xlat_i), .xlat_va_i(xlat_va_i), .xlat_hit_o(xlat_hit_o),
  .exc_i(exc_i), .exc_pc_i(exc_pc_i), .exc_in_slot_i(exc_in_slot_i),
  .exc_taken_o(exc_taken_o), .fetch_vec_o(fetch_vec_o),
  .kernel_mode_o(kernel_mode_o), .int_enable_o(int_enable_o));

// File: testbench/cptx_pipe_model.sv
// Pipeline model: issues one coprocessor operation at a time.
// Assumes the core clock; lines change just after a rising edge.
`timescale 1ns/10ps
module cptx_pipe_model
(
  input  wire        sys_clk_i, // Core clock
  output reg  [9:0]  strobe_o,  // exc,xlat,ilt,ist,ll,wr,wi,r,p,mtc
  output reg  [4:0]  reg_num_o, // Register number or exception code
  output reg  [63:0] data_o,    // Shared data and address lines
  output reg         flag_o     // Store or delay-slot flag
);
  // Idle lines at time zero
  initial
  begin
    strobe_o = 10'h000;
    reg_num_o = 5'h00;
    data_o = 64'h0;
    flag_o = 1'b0;
  end
  // One request edge, then strobes drop, data and flag lines carry inverse values
  task issue(input [9:0] sel, input [4:0] num, input [63:0] d,
             input f, input [4:0] nxt);
  begin
    @(posedge sys_clk_i);
    strobe_o <= sel;
    reg_num_o <= num;
    data_o <= d;
    flag_o <= f;
    @(posedge sys_clk_i);
    strobe_o <= 10'h000;
    reg_num_o <= nxt;
    data_o <= ~d;
    flag_o <= ~f;
    @(negedge sys_clk_i);
  end
  endtask
endmodule

// File: testbench/testbench.sv
// Self-checking bench for the control coprocessor core.
// Assumes a 250 MHz core clock and the pipeline model beside it.
`timescale 1ns/10ps
`include "cptx_regs.vh"
module testbench;
  reg         sys_clk_i;   // Core clock
  reg         rst_b_i;     // Reset, active low
  reg  [2:0]  ratio;       // Clock ratio strap
  reg  [3:0]  pat;         // Write pattern strap
  reg         be;          // Byte order strap
  wire [9:0]  stb;         // Model strobes
  wire [4:0]  rnum;        // Register number
  wire [63:0] dat;         // Shared data
  wire        flag;        // Store or slot
  wire [63:0] rdata;       // Read data
  wire [31:0] tag_o;       // Tag with parity
  wire [35:0] pa;          // Physical address
  wire        unc;         // Uncached
  wire        hit;         // Valid translation
  wire        taken;       // Exception entry
  wire [63:0] vec;         // Redirect target
  wire        kern;        // Kernel mode
  wire        ie;          // Interrupts on
  integer     miscompares; // Mismatch count
  integer     checks;      // Comparison count
  localparam [9:0] MTC = 10'h001, TLB_PROBE_OP = 10'h002, TLB_READ_OP = 10'h004,
    TLB_WRITE_INDEXED_OP = 10'h008, TLB_WRITE_RANDOM_OP = 10'h010, LL = 10'h020, IST = 10'h040,
    ILT = 10'h080, XL = 10'h100, EXC = 10'h200;
  cptx_pipe_model u_cptx_pipe_model (.sys_clk_i(sys_clk_i),
    .strobe_o(stb), .reg_num_o(rnum), .data_o(dat), .flag_o(flag));
  cptx_core u_cptx_core (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .mode_clk_ratio_i(ratio), .mode_wr_pattern_i(pat),
    .mode_big_end_i(be), .mtc_i(stb[0]), .reg_num_i(rnum),
    .wdata_i(dat), .rdata_o(rdata), .tlb_probe_op_i(stb[1]), .tlb_read_op_i(stb[2]),
    .tlb_write_indexed_op_i(stb[3]), .tlb_write_random_op_i(stb[4]), .ll_i(stb[5]),
    .ll_paddr_i(dat[35:0]), .ist_i(stb[6]), .ilt_i(stb[7]),
    .cache_tag_i(dat[31:0]), .cache_tag_o(tag_o), .xlat_i(stb[8]),
    .xlat_store_i(flag), .xlat_va_i(dat), .xlat_pa_o(pa),
    .xlat_uncached_o(unc), .xlat_hit_o(hit), .exc_i(stb[9]),
    .exc_code_i(rnum), .exc_pc_i(dat), .exc_in_slot_i(flag),
    .exc_taken_o(taken), .fetch_vec_o(vec), .kernel_mode_o(kern),
    .int_enable_o(ie));
  // Clock: 4 ns period
  always #2 sys_clk_i = ~sys_clk_i;
  // Compare and count
  task chk(input [63:0] seen, input [63:0] exp);
  begin
    checks = checks + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask
  task rd(input [4:0] n); u_cptx_pipe_model.issue(10'h0, 0, 0, 0, n);
  endtask
  task wr(input [4:0] n, input [63:0] d);
    u_cptx_pipe_model.issue(MTC, n, d, 1'b0, n);
  endtask
  // Reset with new straps held for 8 cycles
  task do_reset(input [2:0] r, input [3:0] p, input b);
  begin
    @(posedge sys_clk_i);
    rst_b_i <= 1'b0;
    ratio <= r;
    pat <= p;
    be <= b;
    repeat (8) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
  end
  endtask
  // Configuration word from straps and write pattern
  task t_config(input [2:0] r, input [3:0] p, input b);
  begin
    rd(`CPTX_IDX_CONFIG);
    chk(rdata[31:0], {1'b0, r, p, 8'h02, b, 15'h64b0});
    wr(`CPTX_IDX_CONFIG, {64{1'b1}});
    chk(rdata[31:0], {1'b0, r, p, 8'h02, b, 15'h64b7});
  end
  endtask
  // Linked address and tag registers
  task t_regs;
  begin
    u_cptx_pipe_model.issue(LL, 0, 64'h987654321, 0, 17);
    chk(rdata[31:0], 32'h98765432);
    wr(`CPTX_IDX_LINKED_LOAD_PHYSICAL_ADDRESS, 64'h1234);
    chk(rdata[31:0], 32'h1234);
    wr(`CPTX_IDX_CACHE_TAG_HIGH, 64'h5a3cf0fe);
    chk(rdata[31:0], 32'h5a3cf0fe);
    wr(`CPTX_IDX_CACHE_TAG_LOW, 64'ha5c30f02);
    chk(rdata[31:0], 32'ha5c30f02);
    u_cptx_pipe_model.issue(IST, 0, 0, 0, 28);
    chk(tag_o, 32'ha5c30f03);
    u_cptx_pipe_model.issue(ILT, 0, 64'h12345678, 0, 28);
    chk(rdata[31:0], 32'h12345678);
  end
  endtask
  // Lookup, probe, read, writes and faults
  task t_tlb;
  begin
    wr(`CPTX_IDX_PAGEMASK, 0);
    wr(`CPTX_IDX_HI, 64'h12346005);
    wr(`CPTX_IDX_LO0, 64'h2af16);
    wr(`CPTX_IDX_LO1, 64'h48da);
    wr(`CPTX_IDX_INDEX, 5);
    wr(`CPTX_IDX_CONTEXT, 64'hffffffffff800000);
    wr(`CPTX_IDX_STATUS, 1);
    u_cptx_pipe_model.issue(TLB_WRITE_INDEXED_OP, 0, 0, 0, 0);
    u_cptx_pipe_model.issue(TLB_PROBE_OP, 0, 0, 0, 0);
    chk(rdata[31:0], 5);
    u_cptx_pipe_model.issue(XL, 0, 64'h12346678, 0, 4);
    chk({hit, unc, taken, pa}, {3'b110, 36'h00abc678});
    u_cptx_pipe_model.issue(XL, 0, 64'h12347010, 1, 13);
    chk({hit, taken, rdata[6:2]}, {2'b01, `CPTX_EXC_MOD});
    wr(`CPTX_IDX_HI, 64'h12346006);
    wr(`CPTX_IDX_STATUS, 1);
    u_cptx_pipe_model.issue(TLB_PROBE_OP, 0, 0, 0, 0);
    chk(rdata[31], 1);
    u_cptx_pipe_model.issue(XL, 0, 64'h12346678, 0, 4);
    chk({hit, taken, ie, kern}, 4'b0101);
    chk(vec, 64'hffffffff80000180);
    chk(rdata, 64'hffffffffff891a30);
    rd(`CPTX_IDX_CAUSE);
    chk(rdata[6:2], `CPTX_EXC_TLBL);
    wr(`CPTX_IDX_INDEX, 5);
    wr(`CPTX_IDX_LO0, 0);
    u_cptx_pipe_model.issue(TLB_READ_OP, 0, 0, 0, 2);
    chk(rdata, 64'h2af16);
    wr(`CPTX_IDX_HI, 64'h20000005);
    wr(`CPTX_IDX_LO0, 64'h2af1e);
    u_cptx_pipe_model.issue(TLB_WRITE_RANDOM_OP, 0, 0, 0, 0);
    u_cptx_pipe_model.issue(XL, 0, 64'h20000044, 0, 0);
    chk({hit, unc, taken, pa}, {3'b100, 36'h00abc044});
  end
  endtask
  // Restart address, plain and in a delay slot
  task t_exc;
  begin
    wr(`CPTX_IDX_STATUS, 1);
    u_cptx_pipe_model.issue(EXC, 5'h0a, 64'hffffffff80001000, 0, 14);
    chk(rdata, 64'hffffffff80001000);
    wr(`CPTX_IDX_STATUS, 1);
    u_cptx_pipe_model.issue(EXC, 5'h0a, 64'hffffffff80001000, 1, 14);
    chk(rdata, 64'hffffffff80000ffc);
    rd(5'h07);
    chk(rdata, 0);
  end
  endtask
  // Verdict and end of run
  task wrap_up;
  begin
    if (miscompares == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  // Main sequence, second reset in mid-run with other straps
  initial
  begin
    miscompares = 0;
    checks = 0;
    sys_clk_i = 1'b0;
    rst_b_i = 1'b0;
    ratio = 3'h5;
    pat = 4'h3;
    be = 1'b1;
    do_reset(3'h5, 4'h3, 1'b1);
    t_config(3'h5, 4'h3, 1'b1);
    t_regs;
    t_tlb;
    t_exc;
    do_reset(3'h6, 4'h8, 1'b0);
    t_config(3'h6, 4'h8, 1'b0);
    wrap_up;
  end
  // Watchdog well beyond the expected run
  initial
  begin
    #200000;
    miscompares = miscompares + 1;
    wrap_up;
  end
endmodule
